// ### include/rat_map.svh
`ifndef RAT_MAP_SVH
`define RAT_MAP_SVH

`define RAT_CNT_W         10
`define RAT_CNT_MAX       10'h3FF
`define RAT_CNT_MIN       10'h000
`define RAT_INIT_RST      10'h200

`define RAT_OFS_CTRL      8'h00
`define RAT_OFS_DIV       8'h04
`define RAT_OFS_INIT_A    8'h08
`define RAT_OFS_INIT_B    8'h0C
`define RAT_OFS_STATUS    8'h10
`define RAT_OFS_VAL_A     8'h14
`define RAT_OFS_VAL_B     8'h18
`define RAT_OFS_IRQ_STAT  8'h1C
`define RAT_OFS_IRQ_CLR   8'h20
`define RAT_OFS_IRQ_EN    8'h24

`define RAT_CTRL_EN_A     0
`define RAT_CTRL_EN_B     1
`define RAT_CTRL_INV      2
`define RAT_CTRL_EXTCLK   3
`define RAT_CTRL_CMP_EN   4
`define RAT_CTRL_VREF_EN  5
`define RAT_CTRL_CH_B     6
`define RAT_CTRL_W        7
`define RAT_CTRL_RST      7'h00

`define RAT_EV_STOP_A     0
`define RAT_EV_STOP_B     1
`define RAT_EV_START_A    2
`define RAT_EV_START_B    3
`define RAT_EV_W          4

`define RAT_DIV_W         16
`define RAT_DIV_RST       16'h00FA
`define RAT_CLK_KHZ       25000
`define RAT_CMP_LIMIT_KHZ 100
`define RAT_DIV_MIN       ((`RAT_CLK_KHZ + `RAT_CMP_LIMIT_KHZ - 1) / `RAT_CMP_LIMIT_KHZ)

`endif

// ### include/rat_pkg.sv
package rat_pkg;
  typedef enum logic [2:0] {
    RAT_ST_IDLE  = 3'b001,
    RAT_ST_RUN_A = 3'b010,
    RAT_ST_RUN_B = 3'b100
  } rat_state_t;

  typedef logic [9:0] rat_code_t;
endpackage

// ### include/rat_step_if.sv
`timescale 1ns/100ps
interface rat_step_if;
  logic                  load;
  rat_pkg::rat_code_t    load_val;
  logic                  start;
  logic                  tick;
  logic                  dir;
  logic                  active;
  rat_pkg::rat_code_t    count;
  logic                  stop;

  modport ctl (output load, output load_val, output start, output tick, output dir, output active,
               input count, input stop);
  modport cnt (input load, input load_val, input start, input tick, input dir, input active,
               output count, output stop);
endinterface

// ### logic/rat_trim_counter.sv
`timescale 1ns/100ps
`include "rat_map.svh"
module rat_trim_counter (
  input  wire logic  i_clk,   // System clock
  input  wire logic  i_rst,   // Synchronous reset, active high
  rat_step_if.cnt    step     // Step control from the sequencer
);
  rat_pkg::rat_code_t count_q, count_d, next_v;
  logic               pdir_q, pdir_d;
  logic               pval_q, pval_d;
  logic               stop_c;

  always_comb begin
    count_d = count_q;
    pdir_d  = pdir_q;
    pval_d  = pval_q;
    stop_c  = 1'b0;
    next_v  = count_q;
    if (step.load) begin
      count_d = step.load_val;
    end
    if (step.start) begin
      pval_d = 1'b0;
    end else if (step.active && step.tick) begin
      pdir_d = step.dir;
      pval_d = 1'b1;
      if (pval_q && (step.dir != pdir_q)) begin
        stop_c = 1'b1;
      end else begin
        if (step.dir) begin
          next_v = (count_q == `RAT_CNT_MAX) ? `RAT_CNT_MAX : count_q + 10'h001;
        end else begin
          next_v = (count_q == `RAT_CNT_MIN) ? `RAT_CNT_MIN : count_q - 10'h001;
        end
        count_d = next_v;
        stop_c  = (next_v == `RAT_CNT_MAX) || (next_v == `RAT_CNT_MIN);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count_q <= `RAT_INIT_RST;
      pdir_q  <= 1'b0;
      pval_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      pdir_q  <= pdir_d;
      pval_q  <= pval_d;
    end
  end

  assign step.count = count_q;
  assign step.stop  = stop_c;

  property p_step_up;
    @(posedge i_clk) disable iff (i_rst)
    step.active && step.tick && !step.start && !step.load && step.dir && !(pval_q && !pdir_q) &&
      count_q != `RAT_CNT_MAX |=> count_q == $past(count_q) + 10'h001;
  endproperty
  a_step_up: assert property (p_step_up) else $error("Counter did not step up");

  property p_step_dn;
    @(posedge i_clk) disable iff (i_rst)
    step.active && step.tick && !step.start && !step.load && !step.dir && !(pval_q && pdir_q) &&
      count_q != `RAT_CNT_MIN |=> count_q == $past(count_q) - 10'h001;
  endproperty
  a_step_dn: assert property (p_step_dn) else $error("Counter did not step down");

  property p_reverse;
    @(posedge i_clk) disable iff (i_rst)
    step.active && step.tick && !step.start && pval_q && (step.dir != pdir_q) |-> step.stop;
  endproperty
  a_reverse: assert property (p_reverse) else $error("Direction change did not stop");

  property p_top_end;
    @(posedge i_clk) disable iff (i_rst)
    step.active && step.tick && !step.start && step.dir && !(pval_q && !pdir_q) &&
      count_q >= 10'h3FE |-> step.stop;
  endproperty
  a_top_end: assert property (p_top_end) else $error("Reaching 1023 did not stop");

  property p_bot_end;
    @(posedge i_clk) disable iff (i_rst)
    step.active && step.tick && !step.start && !step.dir && !(pval_q && pdir_q) &&
      count_q <= 10'h001 |-> step.stop;
  endproperty
  a_bot_end: assert property (p_bot_end) else $error("Reaching 0 did not stop");
endmodule // rat_trim_counter

// ### logic/rat_top.sv
`timescale 1ns/100ps
`include "rat_map.svh"
module rat_top #(
  parameter int DIV_W = `RAT_DIV_W  // Width of the internal trim clock divider
) (
  input  wire logic        i_clk,                  // System clock, 25 MHz
  input  wire logic        i_rst,                  // Synchronous reset, active high
  input  wire logic        i_trim_trigger_a,       // Trim trigger pin, unit a
  input  wire logic        i_trim_trigger_b,       // Trim trigger pin, unit b
  input  wire logic        i_chopped_comparator,   // Comparator output pin
  input  wire logic        i_ext_trim_clk,         // External trim clock pin
  input  wire logic [7:0]  i_addr,                 // Register byte address
  input  wire logic [31:0] i_wdata,                // Register write data
  input  wire logic        i_wr,                   // Write strobe
  input  wire logic        i_rd,                   // Read strobe
  output logic      [31:0] o_rdata,                // Read data, cycle after strobe
  output logic             o_irq,                  // Level interrupt
  output logic      [9:0]  o_resistor_unit_a,      // Rheostat code, unit a
  output logic      [9:0]  o_resistor_unit_b,      // Rheostat code, unit b
  output logic             o_trim_idle_flag,       // High when no run active
  output logic             o_comparator_enable,    // Comparator power enable
  output logic             o_vref_enable,          // Reference power enable
  output logic             o_comparator_channel_b  // High selects channel b
);
  localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(`RAT_DIV_MIN);

  function automatic logic rat_rise(input logic now_v, input logic old_v);
    return now_v & ~old_v;
  endfunction

  // Pin synchronisers: bit 0 trig a, 1 trig b, 2 comparator, 3 ext clock
  logic [3:0] s1_q, s2_q, s3_q, filt_q, filt_d;
  logic [3:0] pins;

  assign pins = {i_ext_trim_clk, i_chopped_comparator, i_trim_trigger_b, i_trim_trigger_a};

  // A level moves only once stages two and three agree, so a single-cycle glitch is dropped
  always_comb begin
    filt_d = (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & filt_q);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_q   <= 4'h0;
      s2_q   <= 4'h0;
      s3_q   <= 4'h0;
      filt_q <= 4'h0;
    end else begin
      s1_q   <= pins;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  logic rise_a, rise_b, ext_rise, dir_lvl;
  assign rise_a   = rat_rise(filt_d[0], filt_q[0]);
  assign rise_b   = rat_rise(filt_d[1], filt_q[1]);
  assign ext_rise = rat_rise(filt_d[3], filt_q[3]);

  // Register file
  logic [`RAT_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [DIV_W-1:0]       div_q, div_d;
  logic [9:0]             init_a_q, init_a_d, init_b_q, init_b_d;
  logic [`RAT_EV_W-1:0]   ist_q, ist_d, ien_q, ien_d, ev;
  logic [31:0]            rdata_q, rdata_d;
  logic                   wr_init_a, wr_init_b;

  assign dir_lvl = filt_q[2] ^ ctrl_q[`RAT_CTRL_INV];

  // Sequencer: one-hot state holds the latched trigger
  rat_pkg::rat_state_t state_q, state_d;
  logic [1:0]          rearm_q, rearm_d;
  logic [DIV_W-1:0]    dcnt_q, dcnt_d, eff_div;
  logic                run_any, int_tick, tick;
  logic                start_a, start_b;
  logic                cmp_en_q, cmp_en_d, vref_en_q, vref_en_d, chb_q, chb_d;

  rat_step_if step_a ();
  rat_step_if step_b ();

  assign run_any = (state_q != rat_pkg::RAT_ST_IDLE);

  // Fast (small) divider setting is clamped so an internal clock never outruns the comparator
  assign eff_div = (div_q < DIV_MIN) ? DIV_MIN : div_q;

  always_comb begin
    dcnt_d   = dcnt_q;
    int_tick = 1'b0;
    if (!run_any) begin
      dcnt_d = '0;
    end else if (dcnt_q >= eff_div - DIV_W'(1)) begin
      dcnt_d   = '0;
      int_tick = 1'b1;
    end else begin
      dcnt_d = dcnt_q + DIV_W'(1);
    end
  end

  assign tick = ctrl_q[`RAT_CTRL_EXTCLK] ? ext_rise : int_tick;

  always_comb begin
    state_d = state_q;
    rearm_d = rearm_q;
    start_a = 1'b0;
    start_b = 1'b0;
    case (state_q)
      rat_pkg::RAT_ST_IDLE: begin
        rearm_d = 2'b00;
        if (ctrl_q[`RAT_CTRL_EN_A] && (rise_a || rearm_q[0])) begin
          start_a = 1'b1;
          state_d = rat_pkg::RAT_ST_RUN_A;
        end else if (ctrl_q[`RAT_CTRL_EN_B] && (rise_b || rearm_q[1])) begin
          start_b = 1'b1;
          state_d = rat_pkg::RAT_ST_RUN_B;
        end
      end
      rat_pkg::RAT_ST_RUN_A: begin
        if (step_a.stop) begin
          state_d    = rat_pkg::RAT_ST_IDLE;
          rearm_d[0] = filt_q[0];
        end
      end
      rat_pkg::RAT_ST_RUN_B: begin
        if (step_b.stop) begin
          state_d    = rat_pkg::RAT_ST_IDLE;
          rearm_d[1] = filt_q[1];
        end
      end
      default: begin
        state_d = rat_pkg::RAT_ST_IDLE;
        rearm_d = 2'b00;
      end
    endcase
  end

  always_comb begin
    cmp_en_d  = ctrl_q[`RAT_CTRL_CMP_EN] | (state_d != rat_pkg::RAT_ST_IDLE);
    vref_en_d = ctrl_q[`RAT_CTRL_VREF_EN] | (state_d != rat_pkg::RAT_ST_IDLE);
    case (state_d)
      rat_pkg::RAT_ST_RUN_A: chb_d = 1'b0;
      rat_pkg::RAT_ST_RUN_B: chb_d = 1'b1;
      default:               chb_d = ctrl_q[`RAT_CTRL_CH_B];
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q   <= rat_pkg::RAT_ST_IDLE;
      rearm_q   <= 2'b00;
      dcnt_q    <= '0;
      cmp_en_q  <= 1'b0;
      vref_en_q <= 1'b0;
      chb_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      rearm_q   <= rearm_d;
      dcnt_q    <= dcnt_d;
      cmp_en_q  <= cmp_en_d;
      vref_en_q <= vref_en_d;
      chb_q     <= chb_d;
    end
  end

  assign step_a.load     = wr_init_a;
  assign step_a.load_val = init_a_d;
  assign step_a.start    = start_a;
  assign step_a.tick     = tick;
  assign step_a.dir      = dir_lvl;
  assign step_a.active   = (state_q == rat_pkg::RAT_ST_RUN_A);
  assign step_b.load     = wr_init_b;
  assign step_b.load_val = init_b_d;
  assign step_b.start    = start_b;
  assign step_b.tick     = tick;
  assign step_b.dir      = dir_lvl;
  assign step_b.active   = (state_q == rat_pkg::RAT_ST_RUN_B);

  rat_trim_counter u_cnt_a (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .step  (step_a)
  );

  rat_trim_counter u_cnt_b (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .step  (step_b)
  );

  // Bus slave; an initial code written during that unit's run updates the register but never loads the counter
  assign wr_init_a = i_wr && (i_addr == `RAT_OFS_INIT_A) && (state_q != rat_pkg::RAT_ST_RUN_A);
  assign wr_init_b = i_wr && (i_addr == `RAT_OFS_INIT_B) && (state_q != rat_pkg::RAT_ST_RUN_B);

  assign ev = {start_b, start_a, step_b.stop & step_b.active, step_a.stop & step_a.active};

  always_comb begin
    ctrl_d   = ctrl_q;
    div_d    = div_q;
    init_a_d = init_a_q;
    init_b_d = init_b_q;
    ien_d    = ien_q;
    ist_d    = ist_q;
    rdata_d  = 32'h0000_0000;
    if (i_wr) begin
      case (i_addr)
        `RAT_OFS_CTRL:    ctrl_d   = i_wdata[`RAT_CTRL_W-1:0];
        `RAT_OFS_DIV:     div_d    = i_wdata[DIV_W-1:0];
        `RAT_OFS_INIT_A:  init_a_d = i_wdata[9:0];
        `RAT_OFS_INIT_B:  init_b_d = i_wdata[9:0];
        `RAT_OFS_IRQ_CLR: ist_d    = ist_q & ~i_wdata[`RAT_EV_W-1:0];
        `RAT_OFS_IRQ_EN:  ien_d    = i_wdata[`RAT_EV_W-1:0];
        default:          ;
      endcase
    end
    ist_d = ist_d | ev; // A new event beats a clear in the same cycle
    if (i_rd) begin
      case (i_addr)
        `RAT_OFS_CTRL:     rdata_d = {25'h0, ctrl_q};
        `RAT_OFS_DIV:      rdata_d = 32'(div_q);
        `RAT_OFS_INIT_A:   rdata_d = {22'h0, init_a_q};
        `RAT_OFS_INIT_B:   rdata_d = {22'h0, init_b_q};
        `RAT_OFS_STATUS:   rdata_d = {26'h0, filt_q[1:0], dir_lvl, ~run_any, state_q[2:1]};
        `RAT_OFS_VAL_A:    rdata_d = {22'h0, step_a.count};
        `RAT_OFS_VAL_B:    rdata_d = {22'h0, step_b.count};
        `RAT_OFS_IRQ_STAT: rdata_d = {28'h0, ist_q};
        `RAT_OFS_IRQ_EN:   rdata_d = {28'h0, ien_q};
        default:           rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_q   <= `RAT_CTRL_RST;
      div_q    <= DIV_W'(`RAT_DIV_RST);
      init_a_q <= `RAT_INIT_RST;
      init_b_q <= `RAT_INIT_RST;
      ist_q    <= 4'h0;
      ien_q    <= 4'h0;
      rdata_q  <= 32'h0000_0000;
    end else begin
      ctrl_q   <= ctrl_d;
      div_q    <= div_d;
      init_a_q <= init_a_d;
      init_b_q <= init_b_d;
      ist_q    <= ist_d;
      ien_q    <= ien_d;
      rdata_q  <= rdata_d;
    end
  end

  assign o_rdata                = rdata_q;
  assign o_irq                  = |(ist_q & ien_q);
  assign o_resistor_unit_a      = step_a.count;
  assign o_resistor_unit_b      = step_b.count;
  assign o_trim_idle_flag       = ~run_any;
  assign o_comparator_enable    = cmp_en_q;
  assign o_vref_enable          = vref_en_q;
  assign o_comparator_channel_b = chb_q;

  property p_start;
    @(posedge i_clk) disable iff (i_rst)
    !run_any && ctrl_q[`RAT_CTRL_EN_A] && rise_a |=> state_q == rat_pkg::RAT_ST_RUN_A ##0 !o_trim_idle_flag;
  endproperty
  a_start: assert property (p_start) else $error("Trigger edge did not start run");

  property p_hold;
    @(posedge i_clk) disable iff (i_rst)
    state_q == rat_pkg::RAT_ST_RUN_A && !step_a.stop |=> state_q == rat_pkg::RAT_ST_RUN_A;
  endproperty
  a_hold: assert property (p_hold) else $error("Latched trigger dropped early");

  property p_force_on;
    @(posedge i_clk) disable iff (i_rst)
    $past(run_any) && run_any |-> o_comparator_enable && o_vref_enable;
  endproperty
  a_force_on: assert property (p_force_on) else $error("Comparator or reference off in run");

  property p_int_quiet;
    @(posedge i_clk) disable iff (i_rst)
    !run_any |-> !int_tick ##1 !int_tick;
  endproperty
  a_int_quiet: assert property (p_int_quiet) else $error("Internal clock ticked while idle");

  property p_stop_idle;
    @(posedge i_clk) disable iff (i_rst)
    step_a.active && step_a.stop |=> o_trim_idle_flag && $rose(o_trim_idle_flag);
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("Stop did not raise idle flag");

  property p_rearm;
    @(posedge i_clk) disable iff (i_rst)
    step_a.active && step_a.stop && filt_q[0] && ctrl_q[`RAT_CTRL_EN_A] && !i_wr |=>
      ##1 state_q == rat_pkg::RAT_ST_RUN_A;
  endproperty
  a_rearm: assert property (p_rearm) else $error("Held trigger did not restart");

  property p_channel;
    @(posedge i_clk) disable iff (i_rst)
    state_q == rat_pkg::RAT_ST_RUN_B && $past(state_q) == rat_pkg::RAT_ST_RUN_B |-> o_comparator_channel_b;
  endproperty
  a_channel: assert property (p_channel) else $error("Wrong comparator channel in run");

  property p_clk_src;
    @(posedge i_clk) disable iff (i_rst)
    run_any && ctrl_q[`RAT_CTRL_EXTCLK] |-> tick == ext_rise;
  endproperty
  a_clk_src: assert property (p_clk_src) else $error("Trim clock source not honoured");
endmodule // rat_top

// ### verification/rat_far_model.sv
`timescale 1ns/100ps
module rat_far_model (
  input  wire logic        i_clk,        // System clock
  input  wire logic [9:0]  i_code_a,     // Rheostat code, unit a
  input  wire logic [9:0]  i_code_b,     // Rheostat code, unit b
  input  wire logic        i_ch_b,       // Channel select from the device
  input  wire logic [10:0] i_set_point,  // Threshold, one bit wider so it can sit above full scale
  input  wire logic        i_invert,     // Output polarity of the comparator
  input  wire logic        i_ext_run,    // Lets the external trim clock run
  output logic             o_comparator, // Comparator level, high below threshold unless i_invert is set
  output logic             o_ext_clk     // External trim clock
);
  logic [7:0] div_q;

  // Sensed node follows the code of whichever channel the device selects
  always_comb begin
    o_comparator = ({1'b0, (i_ch_b ? i_code_b : i_code_a)} < i_set_point) ^ i_invert;
  end

  // A 256-cycle half period keeps the steps slower than the comparator can follow
  always @(posedge i_clk) begin
    if (!i_ext_run) begin
      o_ext_clk <= 1'b0; // Stands still outside a trim run
      div_q     <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
      if (div_q == 8'hFF) begin
        o_ext_clk <= ~o_ext_clk;
      end
    end
  end
endmodule // rat_far_model

// ### verification/test_rat_top.sv
`timescale 1ns/100ps
`include "rat_map.svh"
module test_rat_top;
  logic        i_clk;
  logic        i_rst;
  logic        trig_a;
  logic        trig_b;
  logic        cmp;
  logic        ext_clk;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        o_irq;
  logic [9:0]  unit_a;
  logic [9:0]  unit_b;
  logic        idle;
  logic        cmp_en;
  logic        vref_en;
  logic        ch_b;
  logic [10:0] set_point;
  logic        invert;
  logic        ext_run;
  logic [31:0] rd;
  int          fails;
  int          total_checks;
  int          cycles;

  rat_top #(.DIV_W(16)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_trim_trigger_a(trig_a), .i_trim_trigger_b(trig_b),
    .i_chopped_comparator(cmp), .i_ext_trim_clk(ext_clk), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_resistor_unit_a(unit_a),
    .o_resistor_unit_b(unit_b), .o_trim_idle_flag(idle), .o_comparator_enable(cmp_en),
    .o_vref_enable(vref_en), .o_comparator_channel_b(ch_b));

  rat_far_model far (
    .i_clk(i_clk), .i_code_a(unit_a), .i_code_b(unit_b), .i_ch_b(ch_b), .i_set_point(set_point),
    .i_invert(invert), .i_ext_run(ext_run), .o_comparator(cmp), .o_ext_clk(ext_clk));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic check(input logic [31:0] act, input logic [31:0] exp, input string msg);
    total_checks++;
    if (act !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, msg, act, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rd = o_rdata;
  endtask

  task automatic wait_idle(input logic lvl, input int lim);
    int n;
    n = 0;
    while (idle !== lvl && n < lim) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check({31'h0, idle}, {31'h0, lvl}, "idle flag");
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Whole run needs well under 10000 cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    i_rst        = 1'b1;
    trig_a       = 1'b0;
    trig_b       = 1'b0;
    i_addr       = 8'h00;
    i_wdata      = 32'h0;
    i_wr         = 1'b0;
    i_rd         = 1'b0;
    set_point    = 11'h000;
    invert       = 1'b0;
    ext_run      = 1'b0;
    fails        = 0;
    total_checks = 0;
    cycles       = 0;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (6) @(posedge i_clk);
    #1;
    check({22'h0, unit_a}, 32'h200, "code a after reset");
    check({29'h0, cmp_en, vref_en, ch_b}, 32'h0, "enables after reset");
    check({31'h0, idle}, 32'h1, "idle after reset");
    bus_rd(`RAT_OFS_STATUS);
    check(rd, 32'h04, "status after reset");
    bus_rd(`RAT_OFS_DIV);
    check(rd, 32'h00FA, "divider reset");
    bus_rd(8'h30);
    check(rd, 32'h0, "unmapped read");
    bus_rd(`RAT_OFS_IRQ_CLR);
    check(rd, 32'h0, "clear register reads zero");
    // Internal clock, counts up from 0x200 and stops on the reversal at 0x203
    bus_wr(`RAT_OFS_IRQ_EN, 32'hF);
    bus_wr(`RAT_OFS_CTRL, 32'h03);
    bus_rd(`RAT_OFS_CTRL);
    check(rd, 32'h03, "control readback");
    set_point = 11'h203;
    @(posedge i_clk);
    trig_a <= 1'b1;
    wait_idle(1'b0, 10);
    check({30'h0, cmp_en, vref_en}, 32'h3, "forced enables in run");
    bus_rd(`RAT_OFS_STATUS);
    check(rd, 32'h19, "status in run a");
    @(posedge i_clk);
    trig_a <= 1'b0;
    wait_idle(1'b1, 1500);
    check({22'h0, unit_a}, 32'h203, "code after reversal");
    repeat (2) @(posedge i_clk);
    #1;
    check({31'h0, cmp_en}, 32'h0, "enable released after stop");
    bus_rd(`RAT_OFS_IRQ_STAT);
    check(rd, 32'h5, "start and stop events a");
    check({31'h0, o_irq}, 32'h1, "interrupt raised");
    bus_wr(`RAT_OFS_IRQ_CLR, 32'hF);
    check({31'h0, o_irq}, 32'h0, "interrupt cleared");
    // External clock with inverted comparator, runs into the top code
    bus_wr(`RAT_OFS_INIT_A, 32'h3FD);
    check({22'h0, unit_a}, 32'h3FD, "initial load a");
    bus_wr(`RAT_OFS_CTRL, 32'h0D);
    invert    = 1'b1;
    set_point = 11'h400;
    @(posedge i_clk);
    trig_a <= 1'b1;
    wait_idle(1'b0, 10);
    ext_run = 1'b1;
    @(posedge i_clk);
    trig_a <= 1'b0;
    wait_idle(1'b1, 1500);
    ext_run = 1'b0;
    check({22'h0, unit_a}, 32'h3FF, "stop at top code");
    bus_rd(`RAT_OFS_VAL_A);
    check(rd, 32'h3FF, "value register a");
    bus_wr(`RAT_OFS_IRQ_CLR, 32'hF);
    // Unit b runs down to the bottom code with its interrupt masked
    bus_wr(`RAT_OFS_IRQ_EN, 32'h0);
    bus_wr(`RAT_OFS_INIT_B, 32'h002);
    bus_wr(`RAT_OFS_CTRL, 32'h02);
    invert    = 1'b0;
    set_point = 11'h000;
    @(posedge i_clk);
    trig_b <= 1'b1;
    wait_idle(1'b0, 10);
    check({31'h0, ch_b}, 32'h1, "channel b in run b");
    @(posedge i_clk);
    trig_b <= 1'b0;
    wait_idle(1'b1, 1000);
    check({22'h0, unit_b}, 32'h0, "stop at bottom code");
    check({31'h0, o_irq}, 32'h0, "masked interrupt");
    bus_rd(`RAT_OFS_IRQ_STAT);
    check(rd, 32'hA, "start and stop events b");
    bus_wr(`RAT_OFS_IRQ_EN, 32'hF);
    check({31'h0, o_irq}, 32'h1, "unmasked interrupt");
    bus_wr(`RAT_OFS_IRQ_CLR, 32'hF);
    // Trigger held high: trimming restarts around the set point
    bus_wr(`RAT_OFS_CTRL, 32'h71);
    set_point = 11'h3FE;
    @(posedge i_clk);
    trig_a <= 1'b1;
    wait_idle(1'b0, 10);
    check({31'h0, ch_b}, 32'h0, "channel a in run a");
    wait_idle(1'b1, 1200);
    check({22'h0, unit_a}, 32'h3FD, "reversal keeps code");
    wait_idle(1'b0, 4);
    @(posedge i_clk);
    trig_a <= 1'b0;
    wait_idle(1'b1, 1200);
    check({22'h0, unit_a}, 32'h3FE, "code after second reversal");
    repeat (600) @(posedge i_clk);
    #1;
    check({31'h0, idle}, 32'h1, "no run without a new edge");
    check({22'h0, unit_a}, 32'h3FE, "no steps while idle");
    check({29'h0, cmp_en, vref_en, ch_b}, 32'h7, "enables follow control when idle");
    end_sim();
  end
endmodule // test_rat_top
